/* File: common/spisf_regs.vh */
// Purpose: Register offsets, field positions and timing counts of the SPI flag block
// Assumes: Byte-wide registers on a plain address/strobe port
// Notes:   Definitions only
`ifndef SPISF_REGS_VH
`define SPISF_REGS_VH

// ======================================================
// Register offsets
`define SPISF_ADDR_W        8
`define SPISF_OFF_RXBUF     8'h9b
`define SPISF_OFF_TXBUF     8'h9a
`define SPISF_OFF_STATUS    8'hea
`define SPISF_OFF_CONFIG    8'he8
`define SPISF_OFF_IRQ_MASK  8'he0

// ======================================================
// Status field positions
`define SPISF_ST_RXOF       5
`define SPISF_ST_RXNEW      4
`define SPISF_ST_RXBF       3
`define SPISF_ST_TXUF       2
`define SPISF_ST_TXEMPTY    1
`define SPISF_ST_TXBF       0

// ======================================================
// Config field positions
`define SPISF_CF_MASTER     0
`define SPISF_CF_OVERWRITE  1
`define SPISF_CF_TRANSFER_IRQ_MODE     2
`define SPISF_CF_RESET      8'h04

// ======================================================
// Timing: serial clock half period
`define SPISF_SCLK_HALF_NS  500
`define SPISF_CLK_NS        10
`define SPISF_HALF_CYC      (`SPISF_SCLK_HALF_NS / `SPISF_CLK_NS)

`endif

/* File: hw/spisf_sync.v */
// Purpose: Two-stage synchroniser for one pin input
// Assumes: Input is asynchronous to ref_clk
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module spisf_sync
(
  input  wire ref_clk,
  input  wire reset_n,
  input  wire pinIn,
  output reg  syncOut
);
  reg meta_r;

  // ======================================================
  // Two flip-flops
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r  <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_r  <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule // spisf_sync

/* File: hw/spisf_clkdiv.v */
// Purpose: Enable pulse generator for the serial half bit
// Assumes: HALF is at least one
// Notes:   Restarts while run is low
`timescale 1ns/1ps
module spisf_clkdiv
#(
  parameter HALF = 50
)
(
  input  wire ref_clk,
  input  wire reset_n,
  input  wire run,
  output reg  tick
);
  reg [15:0] count_r;

  // ======================================================
  // Count up to a one-cycle tick
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_r <= 16'h0000;
      tick    <= 1'b0;
    end
    else if (!run)
    begin
      count_r <= 16'h0000;
      tick    <= 1'b0;
    end
    else if (count_r == HALF[15:0] - 16'h0001)
    begin
      count_r <= 16'h0000;
      tick    <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 16'h0001;
      tick    <= 1'b0;
    end
  end
endmodule // spisf_clkdiv

/* File: hw/spisf_core.v */
// Purpose: SPI double-buffered data path with status flags and pin direction
// Assumes: Mode 0 clocking; slave clock and select arrive on pins
// Notes:   Status bits 1,2,0 clear by writing zero; rx bits clear on buffer read
//          A hardware set wins over a software clear in the same cycle
//          Overflow keeps the old byte unless overwrite is enabled
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "spisf_regs.vh"
module spisf_core
(
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdata,
  output reg        irq,
  output reg        sclkOut,
  output reg        sclkOe,
  output reg        selectOutN,
  input  wire       sclkIn,
  input  wire       selectInN,
  input  wire       misoIn,
  output reg        misoOut,
  output reg        misoOe,
  input  wire       mosiIn,
  output reg        mosiOut,
  output reg        mosiOe
);
  // ======================================================
  // Transfer states
  localparam ST_IDLE = 2'd0;
  localparam ST_XFER = 2'd1;
  localparam ST_DONE = 2'd2;

  // Buffers, shifter, flags and transfer progress
  reg [7:0] rxBuf_r;
  reg [7:0] txBuf_r;
  reg [7:0] shift_r;
  reg [7:0] config_r;
  reg [5:0] status_r;
  reg [5:0] mask_r;
  reg [1:0] state_r;
  reg [2:0] bitCnt_r;
  reg       phase_r;
  reg       txLoaded_r;
  reg       sclkPrev_r;
  reg       rxSample_r;
  reg       selPrev_r;

  // Synchronised pins and divider tick
  wire sclkS;
  wire selS;
  wire misoS;
  wire mosiS;
  wire tick;

  // Config fields and register decodes
  wire isMaster  = config_r[`SPISF_CF_MASTER];
  wire overwrite = config_r[`SPISF_CF_OVERWRITE];
  wire transfer_irq_mode    = config_r[`SPISF_CF_TRANSFER_IRQ_MODE];
  wire rdRx      = regRd && (regAddr == `SPISF_OFF_RXBUF);
  wire wrTx      = regWr && (regAddr == `SPISF_OFF_TXBUF);
  wire wrStat    = regWr && (regAddr == `SPISF_OFF_STATUS);
  wire dataIn    = isMaster ? misoS : mosiS;
  wire running   = (state_r == ST_XFER);

  // ======================================================
  // Pin synchronisers and bit-rate divider
  spisf_sync uSyncSclk
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn  (sclkIn),
    .syncOut(sclkS)
  );
  spisf_sync uSyncSel
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn  (selectInN),
    .syncOut(selS)
  );
  spisf_sync uSyncMiso
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn  (misoIn),
    .syncOut(misoS)
  );
  spisf_sync uSyncMosi
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pinIn  (mosiIn),
    .syncOut(mosiS)
  );
  spisf_clkdiv #(.HALF(`SPISF_HALF_CYC)) uDiv
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run    (running && isMaster),
    .tick   (tick)
  );

  // Edge events: master uses divider phase, slave uses pin clock edges
  wire sampleEv = isMaster ? (tick && !phase_r) : (sclkS && !sclkPrev_r && !selS);
  wire shiftEv  = isMaster ? (tick && phase_r)  : (!sclkS && sclkPrev_r && !selS);
  wire byteEnd  = shiftEv && (bitCnt_r == 3'd7);

  // Next-byte readiness checks for the stop decision
  wire rxBlocks = !transfer_irq_mode && status_r[`SPISF_ST_RXNEW] && !rdRx;
  wire txBlocks = transfer_irq_mode && !txLoaded_r && !wrTx;

  // ======================================================
  // Register write, status flags and data path
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxBuf_r    <= 8'h00;
      txBuf_r    <= 8'h00;
      shift_r    <= 8'h00;
      config_r   <= `SPISF_CF_RESET;
      status_r   <= 6'h02;
      mask_r     <= 6'h00;
      state_r    <= ST_IDLE;
      bitCnt_r   <= 3'd0;
      phase_r    <= 1'b0;
      txLoaded_r <= 1'b0;
      sclkPrev_r <= 1'b0;
      rxSample_r <= 1'b0;
      selPrev_r  <= 1'b0; // Synced select starts low; no false start edge
    end
    else
    begin
      // Edge history of the pin clock and select
      sclkPrev_r <= sclkS;
      selPrev_r  <= selS;
      // Config and mask registers
      if (regWr && regAddr == `SPISF_OFF_CONFIG)
        config_r <= regWdata;
      if (regWr && regAddr == `SPISF_OFF_IRQ_MASK)
        mask_r <= regWdata[5:0];

      // Software clears first; hardware sets below win
      if (rdRx)
      begin
        status_r[`SPISF_ST_RXOF]  <= 1'b0;
        status_r[`SPISF_ST_RXNEW] <= 1'b0;
        status_r[`SPISF_ST_RXBF]  <= 1'b0;
      end
      if (wrStat)
      begin
        if (!regWdata[`SPISF_ST_TXUF])
          status_r[`SPISF_ST_TXUF] <= 1'b0;
        if (!regWdata[`SPISF_ST_TXEMPTY])
          status_r[`SPISF_ST_TXEMPTY] <= 1'b0;
        if (!regWdata[`SPISF_ST_TXBF])
          status_r[`SPISF_ST_TXBF] <= 1'b0;
      end
      if (wrTx)
      begin
        txBuf_r    <= regWdata;
        txLoaded_r <= 1'b1;
        status_r[`SPISF_ST_TXEMPTY] <= 1'b0;
        status_r[`SPISF_ST_TXBF]    <= 1'b1;
      end

      // Sample on the first half bit, shift on the second
      if (sampleEv)
      begin
        rxSample_r <= dataIn;
        phase_r    <= 1'b1;
      end
      if (shiftEv)
      begin
        phase_r  <= 1'b0;
        bitCnt_r <= bitCnt_r + 3'd1;
        shift_r  <= {shift_r[6:0], rxSample_r};
      end

      // Transfer sequencing
      case (state_r)
        ST_IDLE:
        begin
          bitCnt_r <= 3'd0;
          phase_r  <= 1'b0;
          // Master starts on loaded data; slave on select falling
          if ((isMaster && txLoaded_r) || (!isMaster && !selS && selPrev_r))
          begin
            shift_r    <= txBuf_r;
            txLoaded_r <= 1'b0;
            status_r[`SPISF_ST_TXEMPTY] <= 1'b1;
            status_r[`SPISF_ST_TXBF]    <= 1'b0;
            if (!txLoaded_r)
              status_r[`SPISF_ST_TXUF] <= 1'b1;
            state_r <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (!isMaster && selS)
            state_r <= ST_IDLE;
          else if (byteEnd)
          begin
            // Completed byte lands in the receive buffer
            if (status_r[`SPISF_ST_RXNEW] && !rdRx)
            begin
              status_r[`SPISF_ST_RXOF] <= 1'b1;
              if (overwrite)
                rxBuf_r <= {shift_r[6:0], rxSample_r};
            end
            else
              rxBuf_r <= {shift_r[6:0], rxSample_r};
            status_r[`SPISF_ST_RXNEW] <= 1'b1;
            status_r[`SPISF_ST_RXBF]  <= 1'b1;
            if (isMaster && (rxBlocks || txBlocks))
              state_r <= ST_DONE;
            else
            begin
              // Next byte from buffer, or underflow
              shift_r    <= txBuf_r;
              txLoaded_r <= 1'b0;
              status_r[`SPISF_ST_TXEMPTY] <= 1'b1;
              status_r[`SPISF_ST_TXBF]    <= 1'b0;
              if (!txLoaded_r && !wrTx)
                status_r[`SPISF_ST_TXUF] <= 1'b1;
              if (wrTx)
                shift_r <= regWdata;
            end
          end
        end
        ST_DONE:
          // One idle cycle lets select rise before any restart
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ======================================================
  // Registered outputs: read data, irq, pins
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdata   <= 8'h00;
      irq        <= 1'b0;
      sclkOut    <= 1'b0;
      sclkOe     <= 1'b0;
      selectOutN <= 1'b1;
      misoOut    <= 1'b0;
      misoOe     <= 1'b0;
      mosiOut    <= 1'b0;
      mosiOe     <= 1'b0;
    end
    else
    begin
      regRdata <= 8'h00;
      if (regRd)
      begin
        case (regAddr)
          `SPISF_OFF_RXBUF:    regRdata <= rxBuf_r;
          `SPISF_OFF_TXBUF:    regRdata <= txBuf_r;
          `SPISF_OFF_STATUS:   regRdata <= {2'b00, status_r};
          `SPISF_OFF_CONFIG:   regRdata <= config_r;
          `SPISF_OFF_IRQ_MASK: regRdata <= {2'b00, mask_r};
          default:             regRdata <= 8'h00;
        endcase
      end
      // Level interrupt from any unmasked flag
      irq        <= |(status_r & mask_r);
      // Pin directions, clock and select follow the master bit
      sclkOe     <= isMaster;
      sclkOut    <= isMaster && running && phase_r;
      selectOutN <= !(isMaster && running);
      misoOe     <= !isMaster;
      mosiOe     <= isMaster;
      // Both data pins show the top bit of the shifter
      misoOut    <= shift_r[7];
      mosiOut    <= shift_r[7];
    end
  end
endmodule // spisf_core

/* File: testbench/spisf_core_assertions.sv */
// Purpose: Port assertions for spisf_core
// Assumes: One clock, async active-low reset
// Notes:   Bound to the core below
`timescale 1ns/1ps
`include "spisf_regs.vh"
module spisf_core_assertions
(
  input wire       ref_clk,
  input wire       reset_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWr,
  input wire       regRd,
  input wire [7:0] regRdata,
  input wire       irq,
  input wire       sclkOut,
  input wire       sclkOe,
  input wire       selectOutN,
  input wire       misoOe,
  input wire       mosiOut,
  input wire       mosiOe
);
  reg       sclkQ_r;
  reg [2:0] riseCnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ======================================================
  // Serial clock rise counter
  always @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sclkQ_r   <= 1'b0;
      riseCnt_r <= 3'h0;
    end
    else
    begin
      sclkQ_r   <= sclkOut;
      riseCnt_r <= riseCnt_r + {2'h0, sclkOut & ~sclkQ_r};
    end
  // ======================================================
  // Register access steps
  sequence s_stat_rd;
    regRd && regAddr == `SPISF_OFF_STATUS;
  endsequence
  sequence s_rx_rd;
    regRd && regAddr == `SPISF_OFF_RXBUF;
  endsequence
  sequence s_stat_zero;
    regWr && regAddr == `SPISF_OFF_STATUS && regWdata == 8'h00;
  endsequence
  a_rx_clear: assert property (s_rx_rd ##[1:2] s_stat_rd |=> regRdata[5:3] == 3'h0)
    else $error("receive flags stayed after buffer read");
  a_tx_clear: assert property (s_stat_zero ##[1:2] s_stat_rd |=> !regRdata[2] && !regRdata[0])
    else $error("transmit flags stayed after zero write");
  a_irq_mask: assert property (regWr && regAddr == `SPISF_OFF_IRQ_MASK && regWdata == 8'h00
    ##1 !(regWr && regAddr == `SPISF_OFF_IRQ_MASK) |=> !irq)
    else $error("interrupt high with all masked");
  a_miso_dir: assert property (!$past(reset_n) || misoOe == !sclkOe)
    else $error("data-in pin direction wrong");
  a_mosi_dir: assert property (mosiOe == sclkOe)
    else $error("data-out pin direction wrong");
  a_mosi_steady: assert property (sclkOe && sclkOut && $past(sclkOut) |-> $stable(mosiOut))
    else $error("data-out changed while clock high");
  a_byte_whole: assert property ($rose(selectOutN) |-> riseCnt_r == 3'h0)
    else $error("select released mid byte");
  a_idle_clock: assert property (selectOutN && sclkOe |-> !sclkOut)
    else $error("clock running while deselected");
endmodule // spisf_core_assertions

bind spisf_core spisf_core_assertions u_chk (.ref_clk, .reset_n, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata, .irq, .sclkOut, .sclkOe, .selectOutN, .misoOe, .mosiOut, .mosiOe);

/* File: testbench/spisf_partner.sv */
// Purpose: Slave device model on the serial pins
// Assumes: Clock idles low, data sampled on rising clock
// Notes:   A released output shows the inverse of its last value
`timescale 1ns/1ps
module spisf_partner
(
  input  wire       sclk,
  input  wire       selN,
  input  wire       mosi,
  input  wire [7:0] reply,
  output reg        miso,
  output reg  [7:0] got
);
  reg [7:0] shiftQ_r;
  initial
  begin
    miso     = 1'b0;
    got      = 8'h00;
    shiftQ_r = 8'h00;
  end
  // ======================================================
  // Load reply and show its top bit on select
  always @(negedge selN)
  begin
    shiftQ_r = reply;
    miso     = reply[7];
  end
  // Release the line when deselected
  always @(posedge selN)
    miso = ~miso;
  // Capture master data on rising clock
  always @(posedge sclk)
    if (!selN)
      got = {got[6:0], mosi};
  // Shift next bit out on falling clock
  always @(negedge sclk)
    if (!selN)
    begin
      shiftQ_r = {shiftQ_r[6:0], 1'b0};
      miso     = shiftQ_r[7];
    end
endmodule // spisf_partner

/* File: testbench/spisf_core_bench.sv */
// Purpose: Self-checking bench for spisf_core
// Assumes: Master transfers against the slave model
// Notes:   Expected flags come from a small model
`timescale 1ns/1ps
`include "spisf_regs.vh"
module spisf_core_bench;
  reg        ref_clk  = 1'b0;
  reg        reset_n  = 1'b0;
  reg  [7:0] regAddr  = 8'h00;
  reg  [7:0] regWdata = 8'h00;
  reg        regWr    = 1'b0;
  reg        regRd    = 1'b0;
  reg  [7:0] reply    = 8'h00;
  reg        slvSelN  = 1'b1;
  reg  [7:0] rv;
  wire [7:0] regRdata;
  wire [7:0] pGot;
  wire       irq, sclkOut, sclkOe, selectOutN, misoOut, misoOe, mosiOut, mosiOe, pMiso;
  wire       misoW = misoOe ? misoOut : pMiso;
  wire       mosiW = mosiOe ? mosiOut : ~mosiOut;
  integer    fails = 0, cmp_count = 0, seed = 81187, expRx = 0, expSt = 0, ow = 0;
  // ======================================================
  // Clock and units
  always #5 ref_clk = ~ref_clk;
  spisf_core dut (.ref_clk, .reset_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq,
    .sclkOut, .sclkOe, .selectOutN, .sclkIn(sclkOe ? sclkOut : 1'b0), .selectInN(slvSelN),
    .misoIn(misoW), .misoOut, .misoOe, .mosiIn(mosiW), .mosiOut, .mosiOe);
  spisf_partner peer (.sclk(sclkOut), .selN(selectOutN), .mosi(mosiW), .reply, .miso(pMiso),
    .got(pGot));
  // ======================================================
  // Bus, compare and closing tasks
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One master byte, model updated from the slave reply
  task xfer;
    integer n;
    reg [7:0] tx;
    tx = $random(seed);
    reply = $random(seed);
    wr(`SPISF_OFF_TXBUF, tx);
    n = 0;
    while (selectOutN && n < 300) begin @(posedge ref_clk); n = n + 1; end
    if (selectOutN) n = 3000; // Select never fell
    while (!selectOutN && n < 3000) begin @(posedge ref_clk); n = n + 1; end
    if (n >= 3000)
    begin
      fails = fails + 1;
      stop_test;
    end
    repeat (4) @(posedge ref_clk);
    chk(pGot, tx);
    if (expSt & 8'h10) expSt = expSt | 8'h20;
    if (!(expSt & 8'h10) || ow) expRx = reply;
    expSt = expSt | 8'h1a;
  endtask
  // ======================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`SPISF_OFF_STATUS); chk(rv, 8'h02);
    rd(`SPISF_OFF_CONFIG); chk(rv, 8'h04);
    rd(8'h10); chk(rv, 8'h00);
    chk({6'h0, misoOe, mosiOe}, 8'h02);
    $display("test reset done");
    wr(`SPISF_OFF_IRQ_MASK, 8'h10);
    wr(`SPISF_OFF_CONFIG, 8'h05);
    repeat (3) @(posedge ref_clk);
    chk({6'h0, misoOe, mosiOe}, 8'h01);
    xfer;
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h3a, expSt[7:0] & 8'h3a);
    chk({7'h0, irq}, 8'h01);
    xfer;
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h38, expSt[7:0] & 8'h38);
    rd(`SPISF_OFF_RXBUF); chk(rv, expRx[7:0]);
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h38, 8'h00);
    expSt = expSt & 8'h07;
    $display("test discard done");
    wr(`SPISF_OFF_CONFIG, 8'h07);
    ow = 1;
    xfer;
    xfer;
    rd(`SPISF_OFF_RXBUF); chk(rv, expRx[7:0]);
    $display("test overwrite done");
    // Slave start with nothing loaded underflows the transmit side
    wr(`SPISF_OFF_CONFIG, 8'h04);
    @(posedge ref_clk) slvSelN <= 1'b0;
    repeat (6) @(posedge ref_clk);
    slvSelN <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h07, 8'h06);
    wr(`SPISF_OFF_IRQ_MASK, 8'h04);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, irq}, 8'h01);
    wr(`SPISF_OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, irq}, 8'h00);
    wr(`SPISF_OFF_TXBUF, $random(seed));
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h07, 8'h05);
    wr(`SPISF_OFF_STATUS, 8'h00);
    rd(`SPISF_OFF_STATUS); chk(rv & 8'h05, 8'h00);
    $display("test slave flags done");
    stop_test;
  end
endmodule // spisf_core_bench
